// File: rtl/timer_counter_pwm_unit_consts.svh
`ifndef TIMER_COUNTER_PWM_UNIT_CONSTS_SVH
`define TIMER_COUNTER_PWM_UNIT_CONSTS_SVH

// ----------------------------------------------------------------------
// Structure of the unit
// ----------------------------------------------------------------------

// Number of independent counter channels.
`define TCP_CH_NUM      4
// Width of every counter, period, compare and capture value.
`define TCP_CNT_W       16
// Width of the dead-band offset, in clock cycles.
`define TCP_DT_W        8

// ----------------------------------------------------------------------
// Reset values and safe levels
// ----------------------------------------------------------------------

// Count value after reset and whenever a channel is disabled.
`define TCP_CNT_RST     16'h0000
// Capture value after reset.
`define TCP_CAP_RST     16'h0000
// Level forced onto the true output while kill is active.
`define TCP_KILL_TRUE   1'h0
// Level forced onto the complementary output while kill is active.
`define TCP_KILL_COMP   1'h0
// Level of both outputs while a channel is disabled.
`define TCP_IDLE_LVL    1'h0

`endif

// File: rtl/timer_counter_pwm_unit_pkg.sv
// ----------------------------------------------------------------------
// Types shared by the timer, counter and PWM unit
// ----------------------------------------------------------------------
package timer_counter_pwm_unit_pkg;

    // A count, period, compare or capture value.
    typedef logic [15:0] cnt_t;

    // A dead-band offset in clock cycles.
    typedef logic [7:0] dt_t;

    // Run state of one counter channel.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HALT
    } run_state_e;

endpackage

// File: rtl/dead_band_gen.sv
`include "timer_counter_pwm_unit_consts.svh"

// ----------------------------------------------------------------------
// Dead-band output stage of one channel
// ----------------------------------------------------------------------
// Splits one raw compare signal into a true and a complementary output.
// Each output turns on only after the raw signal has been stable for
// dead_time cycles, while it turns off at once, so the two are never on
// together. The delay is shared by both edges, which keeps it symmetric.
module dead_band_gen (
    // Clock and reset.
    input  wire logic                            clk_sys,
    input  wire logic                            rst_n,
    // Control.
    input  wire logic                            enable,
    input  wire logic                            kill,
    input  wire timer_counter_pwm_unit_pkg::dt_t dead_time,
    // Raw compare signal.
    input  wire logic                            raw,
    // Outputs.
    output logic                                 out_true,
    output logic                                 out_comp
);

    logic                            raw_q_r;    // Last seen raw level.
    logic                            raw_q_nxt;
    timer_counter_pwm_unit_pkg::dt_t hold_r;     // Cycles since a change.
    timer_counter_pwm_unit_pkg::dt_t hold_nxt;
    logic                            true_r;     // Registered true output.
    logic                            true_nxt;
    logic                            comp_r;     // Registered complement.
    logic                            comp_nxt;
    logic                            settled;    // Delay has elapsed.

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // A change of raw restarts the hold count; the count saturates at
    // the offset. Comparing with >= keeps the outputs sane if the offset
    // is lowered while a hold is in progress.
    always_comb begin
        raw_q_nxt = raw;
        hold_nxt  = hold_r;
        if (raw != raw_q_r) begin
            hold_nxt = 8'h00;
        end else if (hold_r < dead_time) begin
            hold_nxt = hold_r + 8'h01;
        end
        settled = (hold_nxt >= dead_time);
        if (!enable) begin
            true_nxt = `TCP_IDLE_LVL;
            comp_nxt = `TCP_IDLE_LVL;
        end else if (kill) begin
            true_nxt = `TCP_KILL_TRUE;
            comp_nxt = `TCP_KILL_COMP;
        end else begin
            true_nxt = raw_q_nxt && settled;
            comp_nxt = !raw_q_nxt && settled;
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            raw_q_r <= 1'h0;
            hold_r  <= 8'h00;
            true_r  <= `TCP_IDLE_LVL;
            comp_r  <= `TCP_IDLE_LVL;
        end else begin
            raw_q_r <= raw_q_nxt;
            hold_r  <= hold_nxt;
            true_r  <= true_nxt;
            comp_r  <= comp_nxt;
        end
    end

    assign out_true = true_r;
    assign out_comp = comp_r;

endmodule // dead_band_gen

// File: rtl/timer_counter_pwm_unit.sv
`include "timer_counter_pwm_unit_consts.svh"

// ----------------------------------------------------------------------
// Four-channel timer, counter and PWM unit
// ----------------------------------------------------------------------
// Each channel counts up from zero to its period. On the period it
// either halts or wraps to zero, as the reload input selects. A rising capture
// pin edge stores the count. The compare value sets the duty of a PWM
// signal that leaves through a dead-band stage with a true and a
// complementary output. A single kill pin forces all outputs safe.

// Behaviour
// - Four independent 16-bit counters, programmable period
// - Capture event stores present count
// - On period match halt or reload
// - Count below compare drives PWM duty
// - True and complement outputs with dead band
// - Kill forces outputs safe without software
module timer_counter_pwm_unit (
    // Clock and reset.
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst_n,
    // Per-channel configuration, steady logic on clk_sys.
    input  wire logic [3:0]                             ch_enable,
    input  wire logic [3:0]                             ch_reload,
    input  wire timer_counter_pwm_unit_pkg::cnt_t [3:0] ch_period,
    input  wire timer_counter_pwm_unit_pkg::cnt_t [3:0] ch_compare,
    input  wire timer_counter_pwm_unit_pkg::dt_t  [3:0] ch_dead_time,
    // Asynchronous pins.
    input  wire logic [3:0]                             capture_pin,
    input  wire logic                                   kill_pin,
    // Channel status.
    output timer_counter_pwm_unit_pkg::cnt_t [3:0]      count,
    output timer_counter_pwm_unit_pkg::cnt_t [3:0]      capture_val,
    output logic [3:0]                                  capture_evt,
    output logic [3:0]                                  period_hit,
    output logic [3:0]                                  running,
    // PWM outputs.
    output logic [3:0]                                  pwm_true,
    output logic [3:0]                                  pwm_comp
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // True when the count has reached the programmed period.
    function automatic logic at_period(
        input timer_counter_pwm_unit_pkg::cnt_t cnt,
        input timer_counter_pwm_unit_pkg::cnt_t per
    );
        at_period = (cnt == per);
    endfunction

    // True on a rising edge of a synchronised level.
    function automatic logic rise(input logic cur, input logic prev);
        rise = cur && !prev;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------

    // Pin synchronisers; stage one is read only by stage two.
    logic [3:0] cap_s1_r;      // Capture pins, first stage.
    logic [3:0] cap_s2_r;      // Capture pins, second stage.
    logic [3:0] cap_prev_r;    // Capture pins, previous settled level.
    logic       kill_s1_r;     // Kill pin, first stage.
    logic       kill_s2_r;     // Kill pin, second stage.

    // Counter state per channel.
    timer_counter_pwm_unit_pkg::run_state_e [3:0] state_r;
    timer_counter_pwm_unit_pkg::run_state_e [3:0] state_nxt;
    timer_counter_pwm_unit_pkg::cnt_t       [3:0] cnt_r;
    timer_counter_pwm_unit_pkg::cnt_t       [3:0] cnt_nxt;
    timer_counter_pwm_unit_pkg::cnt_t       [3:0] cap_r;
    timer_counter_pwm_unit_pkg::cnt_t       [3:0] cap_nxt;
    logic [3:0]                                   cap_evt_r;
    logic [3:0]                                   cap_evt_nxt;
    logic [3:0]                                   hit_r;
    logic [3:0]                                   hit_nxt;
    logic [3:0]                                   pwm_raw_r;
    logic [3:0]                                   pwm_raw_nxt;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Both pins come from outside the clock domain. Going through two
    // flip-flops costs kill two cycles of latency; that is the price of
    // a metastability-free safe state and stays far below any software
    // reaction time.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_s1_r   <= 4'h0;
            cap_s2_r   <= 4'h0;
            cap_prev_r <= 4'h0;
            kill_s1_r  <= 1'h0;
            kill_s2_r  <= 1'h0;
        end else begin
            cap_s1_r   <= capture_pin;
            cap_s2_r   <= cap_s1_r;
            cap_prev_r <= cap_s2_r;
            kill_s1_r  <= kill_pin;
            kill_s2_r  <= kill_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Counter next-state logic
    // ------------------------------------------------------------------
    // Channels are independent; the loop only spares repetition.
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        cap_nxt     = cap_r;
        cap_evt_nxt = 4'h0;
        hit_nxt     = 4'h0;
        pwm_raw_nxt = 4'h0;
        for (int ch = 0; ch < `TCP_CH_NUM; ch++) begin
            unique case (state_r[ch])
                // Stopped with the count cleared.
                timer_counter_pwm_unit_pkg::ST_IDLE: begin
                    cnt_nxt[ch] = `TCP_CNT_RST;
                    if (ch_enable[ch]) begin
                        state_nxt[ch] = timer_counter_pwm_unit_pkg::ST_RUN;
                    end
                end
                // Counting up one step per clock.
                timer_counter_pwm_unit_pkg::ST_RUN: begin
                    if (!ch_enable[ch]) begin
                        state_nxt[ch] = timer_counter_pwm_unit_pkg::ST_IDLE;
                        cnt_nxt[ch]   = `TCP_CNT_RST;
                    end else if (at_period(cnt_r[ch], ch_period[ch])) begin
                        hit_nxt[ch] = 1'h1;
                        if (ch_reload[ch]) begin
                            cnt_nxt[ch] = `TCP_CNT_RST;
                        end else begin
                            state_nxt[ch] =
                                timer_counter_pwm_unit_pkg::ST_HALT;
                        end
                    end else begin
                        cnt_nxt[ch] = cnt_r[ch] + 16'h0001;
                    end
                end
                // Halted on the period until the channel is disabled.
                timer_counter_pwm_unit_pkg::ST_HALT: begin
                    if (!ch_enable[ch]) begin
                        state_nxt[ch] = timer_counter_pwm_unit_pkg::ST_IDLE;
                        cnt_nxt[ch]   = `TCP_CNT_RST;
                    end
                end
                // The two-bit state has one unused code; recover to idle.
                default: begin
                    state_nxt[ch] = timer_counter_pwm_unit_pkg::ST_IDLE;
                    cnt_nxt[ch]   = `TCP_CNT_RST;
                end
            endcase

            if (ch_enable[ch] && rise(cap_s2_r[ch], cap_prev_r[ch])) begin
                cap_nxt[ch]     = cnt_r[ch];
                cap_evt_nxt[ch] = 1'h1;
            end

            if (state_nxt[ch] != timer_counter_pwm_unit_pkg::ST_IDLE) begin
                pwm_raw_nxt[ch] = (cnt_nxt[ch] < ch_compare[ch]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter state registers
    // ------------------------------------------------------------------
    // reset disabled and cleared
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Element by element, so each enum gets one of its own names.
            for (int ch = 0; ch < `TCP_CH_NUM; ch++) begin
                state_r[ch] <= timer_counter_pwm_unit_pkg::ST_IDLE;
            end
            cnt_r     <= {4{`TCP_CNT_RST}};
            cap_r     <= {4{`TCP_CAP_RST}};
            cap_evt_r <= 4'h0;
            hit_r     <= 4'h0;
            pwm_raw_r <= 4'h0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            cap_r     <= cap_nxt;
            cap_evt_r <= cap_evt_nxt;
            hit_r     <= hit_nxt;
            pwm_raw_r <= pwm_raw_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Output stages
    // ------------------------------------------------------------------
    // One dead-band stage per channel; all share the synchronised kill.
    for (genvar g = 0; g < `TCP_CH_NUM; g++) begin : g_out
        dead_band_gen u_dead_band (
            .clk_sys   (clk_sys),
            .rst_n     (rst_n),
            .enable    (ch_enable[g]),
            .kill      (kill_s2_r),
            .dead_time (ch_dead_time[g]),
            .raw       (pwm_raw_r[g]),
            .out_true  (pwm_true[g]),
            .out_comp  (pwm_comp[g])
        );
    end

    // Status outputs straight from flip-flops.
    assign count       = cnt_r;
    assign capture_val = cap_r;
    assign capture_evt = cap_evt_r;
    assign period_hit  = hit_r;

    // A channel is running while it is counting, not while halted.
    always_comb begin
        for (int ch = 0; ch < `TCP_CH_NUM; ch++) begin
            running[ch] = (state_r[ch] == timer_counter_pwm_unit_pkg::ST_RUN);
        end
    end

endmodule // timer_counter_pwm_unit

// File: dv/timer_counter_pwm_unit_assertions.sv
// ----------------------------------------------------------------------
// Port checker for the timer, counter and PWM unit
// ----------------------------------------------------------------------
module timer_counter_pwm_unit_checker (
    // Clock and reset.
    input wire logic                                   clk_sys,
    input wire logic                                   rst_n,
    // Configuration.
    input wire logic [3:0]                             ch_enable,
    input wire logic [3:0]                             ch_reload,
    input wire timer_counter_pwm_unit_pkg::cnt_t [3:0] ch_period,
    input wire timer_counter_pwm_unit_pkg::cnt_t [3:0] ch_compare,
    input wire timer_counter_pwm_unit_pkg::dt_t  [3:0] ch_dead_time,
    // Pins.
    input wire logic [3:0]                             capture_pin,
    input wire logic                                   kill_pin,
    // Status and outputs.
    input wire timer_counter_pwm_unit_pkg::cnt_t [3:0] count,
    input wire timer_counter_pwm_unit_pkg::cnt_t [3:0] capture_val,
    input wire logic [3:0]                             capture_evt,
    input wire logic [3:0]                             period_hit,
    input wire logic [3:0]                             running,
    input wire logic [3:0]                             pwm_true,
    input wire logic [3:0]                             pwm_comp
);
    timeunit 1ns;
    timeprecision 1ps;

    // All checks share the system clock and its reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_count_step_up: assert property (
        running[0] && ch_enable[0] && count[0] < ch_period[0]
        |=> count[0] == $past(count[0]) + 16'h0001)
        else $error("count did not step by one");
    a_reload_wrap: assert property (
        running[0] && ch_enable[0] && ch_reload[0]
        && count[0] == ch_period[0] |=> count[0] == 16'h0000 && period_hit[0])
        else $error("reload did not wrap to zero");
    a_halt_holds: assert property (
        running[0] && ch_enable[0] && !ch_reload[0]
        && count[0] == ch_period[0]
        |=> count[0] == $past(count[0]) && !running[0] && period_hit[0])
        else $error("halt did not stop at period");
    a_capture_value: assert property (
        capture_evt[0] |-> capture_val[0] == $past(count[0]))
        else $error("capture value is not the count");
    a_no_overlap: assert property (
        (pwm_true & pwm_comp) == 4'h0)
        else $error("true and complement high together");
    a_kill_safe: assert property (
        kill_pin [*3] |=> (pwm_true | pwm_comp) == 4'h0)
        else $error("kill did not force outputs low");
    a_disable_clears: assert property (
        !ch_enable[0] |=> count[0] == 16'h0000 && !running[0])
        else $error("disabled channel not cleared");
    a_idle_quiet: assert property (
        !ch_enable[0] [*3] |-> !pwm_true[0] && !pwm_comp[0] && !capture_evt[0])
        else $error("disabled channel drives outputs");
endmodule // timer_counter_pwm_unit_checker

bind timer_counter_pwm_unit timer_counter_pwm_unit_checker chk_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ch_enable(ch_enable),
    .ch_reload(ch_reload), .ch_period(ch_period), .ch_compare(ch_compare),
    .ch_dead_time(ch_dead_time), .capture_pin(capture_pin),
    .kill_pin(kill_pin), .count(count), .capture_val(capture_val),
    .capture_evt(capture_evt), .period_hit(period_hit), .running(running),
    .pwm_true(pwm_true), .pwm_comp(pwm_comp));

// File: dv/tb_top.sv
// ----------------------------------------------------------------------
// Self-checking bench for the timer, counter and PWM unit
// ----------------------------------------------------------------------
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                                   clk_sys = 1'h0;
    logic                                   rst_n   = 1'h0;
    logic [3:0]                             ch_enable = 4'h0;
    logic [3:0]                             ch_reload = 4'h0;
    timer_counter_pwm_unit_pkg::cnt_t [3:0] ch_period = '0;
    timer_counter_pwm_unit_pkg::cnt_t [3:0] ch_compare = '0;
    timer_counter_pwm_unit_pkg::dt_t  [3:0] ch_dead_time = '0;
    logic [3:0]                             capture_pin = 4'h0;
    logic                                   kill_pin = 1'h0;
    timer_counter_pwm_unit_pkg::cnt_t [3:0] count;
    timer_counter_pwm_unit_pkg::cnt_t [3:0] capture_val;
    logic [3:0]                             capture_evt;
    logic [3:0]                             period_hit;
    logic [3:0]                             running;
    logic [3:0]                             pwm_true;
    logic [3:0]                             pwm_comp;
    int                                     errors = 0;
    int                                     check_count = 0;

    // The 100 MHz system clock.
    always #5 clk_sys = ~clk_sys;

    timer_counter_pwm_unit uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ch_enable(ch_enable),
        .ch_reload(ch_reload), .ch_period(ch_period),
        .ch_compare(ch_compare), .ch_dead_time(ch_dead_time),
        .capture_pin(capture_pin), .kill_pin(kill_pin), .count(count),
        .capture_val(capture_val), .capture_evt(capture_evt),
        .period_hit(period_hit), .running(running),
        .pwm_true(pwm_true), .pwm_comp(pwm_comp));

    // Inputs change and outputs are read at the falling edge.
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic stop_test;
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Two channels at different periods wrap on their own schedule.
    task automatic t_reload;
        ch_period[0] = 16'h0003;
        ch_period[1] = 16'h0005;
        ch_reload = 4'h3;
        ch_enable = 4'h3;
        cyc(1);
        for (int k = 0; k < 14; k++) begin
            chk("count0", 16'(k % 4), count[0]);
            chk("count1", 16'(k % 6), count[1]);
            chk("hit0", 16'(k > 0 && k % 4 == 0), 16'(period_hit[0]));
            cyc(1);
        end
        ch_enable = 4'h0;
        cyc(2);
        chk("count_off", 16'h0000, count[0] | count[1]);
        chk("pwm_off", 16'h0000, 16'(pwm_true | pwm_comp));
    endtask

    // A halting channel stops at its period and stays there.
    task automatic t_halt;
        ch_period[2] = 16'h0004;
        ch_enable[2] = 1'h1;
        cyc(1);
        for (int k = 0; k < 9; k++) begin
            chk("count2", 16'(k < 4 ? k : 4), count[2]);
            chk("run2", 16'(k <= 4), 16'(running[2]));
            cyc(1);
        end
        ch_enable[2] = 1'h0;
    endtask

    // Duty with no dead band, then kill and its release.
    task automatic t_pwm_kill;
        int hi_t;
        int hi_c;
        hi_t = 0;
        hi_c = 0;
        ch_period[0] = 16'h0003;
        ch_compare[0] = 16'h0002;
        ch_reload[0] = 1'h1;
        ch_enable[0] = 1'h1;
        cyc(6);
        for (int k = 0; k < 8; k++) begin
            hi_t += int'(pwm_true[0]);
            hi_c += int'(pwm_comp[0]);
            chk("pwm_xor", 16'h0001, 16'(pwm_true[0] ^ pwm_comp[0]));
            cyc(1);
        end
        chk("duty_t", 16'h0004, 16'(hi_t));
        chk("duty_c", 16'h0004, 16'(hi_c));
        kill_pin = 1'h1;
        cyc(3);
        for (int k = 0; k < 5; k++) begin
            chk("kill_out", 16'h0000, 16'(pwm_true | pwm_comp));
            cyc(1);
        end
        kill_pin = 1'h0;
        cyc(4);
        chk("unkill", 16'h0001, 16'(pwm_true[0] ^ pwm_comp[0]));
    endtask

    // A dead band leaves cycles where neither output is high.
    task automatic t_dead_band;
        int hi_t;
        int gap;
        hi_t = 0;
        gap = 0;
        ch_enable[0] = 1'h0;
        ch_period[0] = 16'h000F;
        ch_compare[0] = 16'h0008;
        ch_dead_time[0] = 8'h03;
        cyc(1);
        ch_enable[0] = 1'h1;
        cyc(20);
        for (int k = 0; k < 16; k++) begin
            hi_t += int'(pwm_true[0]);
            gap += int'(!pwm_true[0] && !pwm_comp[0]);
            cyc(1);
        end
        // Sixteen-cycle period, eight raw high, three cycles lost per edge.
        chk("db_true", 16'h0005, 16'(hi_t));
        chk("db_gap", 16'h0006, 16'(gap));
    endtask

    // A pin edge captures the count; a disabled channel ignores it.
    task automatic t_capture;
        logic [15:0] e;
        int hit;
        hit = 0;
        capture_pin = 4'h9;
        for (int i = 0; i < 10 && hit == 0; i++) begin
            cyc(1);
            if (i == 3)
                capture_pin = 4'h0;
            if (capture_evt[0] === 1'h1) begin
                hit = 1;
                e = (count[0] == 16'h0000) ? ch_period[0]
                                           : count[0] - 16'h0001;
                chk("cap_val", e, capture_val[0]);
            end
        end
        capture_pin = 4'h0;
        chk("cap_seen", 16'h0001, 16'(hit));
        cyc(8);
        chk("cap_off", 16'h0000, capture_val[3]);
    endtask

    // A reset in mid-run clears a live channel at once and keeps it quiet.
    task automatic t_reset;
        ch_enable = 4'h1;
        cyc(4);
        rst_n = 1'h0;
        cyc(1);
        chk("mid_cnt", 16'h0000, count[0]);
        chk("mid_cap", 16'h0000, capture_val[0]);
        chk("mid_out", 16'h0000, 16'({running, pwm_true, pwm_comp}));
        ch_enable = 4'h0;
        rst_n = 1'h1;
        cyc(2);
        chk("post_cnt", 16'h0000, count[0]);
        chk("post_out", 16'h0000, 16'({running, pwm_true, pwm_comp}));
    endtask

    // Main sequence.
    initial begin
        cyc(6);
        rst_n = 1'h1;
        chk("rst_cnt", 16'h0000, count[0] | count[3]);
        chk("rst_out", 16'h0000, 16'({running, pwm_true, pwm_comp}));
        cyc(1);
        t_reload();
        t_halt();
        t_pwm_kill();
        t_dead_band();
        t_capture();
        t_reset();
        stop_test();
    end

    // Cuts a hang short well past the expected run time.
    initial begin
        #20us;
        errors++;
        stop_test();
    end
endmodule // tb_top
